// File: pkg/ssd_pkg.sv
// Shared constants, carrier types and phases of the boot strap decoder
package ssd_pkg;

  // Core clock rate
  localparam int unsigned CLK_FREQ_MHZ   = 100;

  // Master SMBus bit rates and the divider counts derived from them
  localparam int unsigned SMBUS_FAST_KHZ = 400;
  localparam int unsigned SMBUS_SLOW_KHZ = 100;
  localparam int unsigned SMBUS_FAST_CYC = (CLK_FREQ_MHZ * 1000) / SMBUS_FAST_KHZ;
  localparam int unsigned SMBUS_SLOW_CYC = (CLK_FREQ_MHZ * 1000) / SMBUS_SLOW_KHZ;
  localparam int unsigned DIV_W          = 10;

  // Internal reset procedure length, a least time so rounded up
  localparam int unsigned RESET_PROC_NS  = 1000;
  localparam int unsigned RESET_PROC_CYC = (RESET_PROC_NS * CLK_FREQ_MHZ + 999) / 1000;

  // Cycles after release before the synchronised straps are trusted
  localparam int unsigned SYNC_SETTLE_CYC = 3;

  // Register bus geometry and map
  localparam int unsigned      ADDR_W          = 8;
  localparam int unsigned      DATA_W          = 32;
  localparam logic [ADDR_W-1:0] OFS_SWITCH_CTL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STRAP_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PORT_CFG   = 8'h08;
  localparam logic [1:0]        RESP_OKAY      = 2'h0;
  localparam logic [1:0]        RESP_DECERR    = 2'h3;

  // Field positions
  localparam int unsigned CTL_HALT_BIT    = 0;
  localparam int unsigned STAT_CLK_LSB    = 0;
  localparam int unsigned STAT_SLOW_BIT   = 3;
  localparam int unsigned STAT_HOLD_BIT   = 4;
  localparam int unsigned STAT_MODE_LSB   = 8;
  localparam int unsigned STAT_MULTI_BIT  = 12;
  localparam int unsigned STAT_EE_BIT     = 13;
  localparam int unsigned STAT_RSVD_BIT   = 14;
  localparam int unsigned STAT_RUN_BIT    = 15;
  localparam int unsigned STAT_UP_LSB     = 16;
  localparam int unsigned STAT_MERGE_LSB  = 24;
  localparam int unsigned PORT_ACT_LSB    = 0;
  localparam int unsigned PORT_X8_LSB     = 16;

  // Geometry of the switch
  localparam int unsigned NUM_PAIRS = 8;
  localparam int unsigned NUM_PORTS = 16;

  // Switch mode codes
  localparam logic [3:0] MODE_SINGLE      = 4'h0;
  localparam logic [3:0] MODE_SINGLE_EE   = 4'h1;
  localparam logic [3:0] MODE_UP0_NO2     = 4'h8;
  localparam logic [3:0] MODE_UP2_NO0     = 4'h9;
  localparam logic [3:0] MODE_UP0_NO2_EE  = 4'hA;
  localparam logic [3:0] MODE_UP2_NO0_EE  = 4'hB;
  localparam logic [3:0] MODE_MULTI       = 4'hC;
  localparam logic [3:0] MODE_MULTI_EE    = 4'hD;
  localparam logic [3:0] PORT_ZERO        = 4'h0;
  localparam logic [3:0] PORT_TWO         = 4'h2;

  // Strap bundle as seen at the pins
  typedef struct packed {
    logic [2:0] clk_mode;
    logic       smbus_slow;
    logic [7:0] merge_n;
    logic       hold;
    logic [3:0] sw_mode;
  } ssd_strap_t;

  localparam int unsigned STRAP_W   = $bits(ssd_strap_t);
  // Unconnected merge straps read as low, so reset shows every pair merged
  localparam ssd_strap_t  STRAP_RST = '{clk_mode: 3'h0, smbus_slow: 1'b0,
                                        merge_n: 8'h00, hold: 1'b0, sw_mode: 4'h0};

  // Boot phases
  typedef enum logic [2:0] {
    PH_SETTLE,
    PH_CAPTURE,
    PH_PROC,
    PH_HALT,
    PH_RUN
  } ssd_phase_t;

endpackage : ssd_pkg

// File: verilog/ssd_sync.sv
// Two-flop synchroniser for a bundle of asynchronous strap levels
`timescale 1ns/1ps
module ssd_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ssd_sync_st_t;

  ssd_sync_st_t s_q;
  ssd_sync_st_t s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d        = s_q;
    s_d.meta   = d_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.stable;

endmodule : ssd_sync

// File: verilog/ssd_strap_decoder.sv
// Boot strap decoder: latches straps, decodes port and mode setup, runs reset halt
// What this block does
// - Three-bit strap selects port clocking mode
// - Slow strap forces master SMBus to 100 KHz
// - Low merge strap joins pair into x8
// - High merge strap keeps two x4 ports
// - Eight active-low merge straps, one per pair
// - Floating merge strap means merged x8 pair
// - Global reset clears all internal logic
// - Hold strap keeps device in reset, SMBus alive
// - Clearing halt bit releases device to run
// - Codes 0x0/0x1: single partition, port 0 up
// - Codes 0x8-0xB: port 0 or 2 upstream
// - Codes 0xC/0xD: multi-partition operation
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module ssd_strap_decoder (
  input  wire logic                        mclk_in,
  input  wire logic                        reset_n_in,
  // Board straps, asynchronous to the core clock
  input  wire logic [2:0]                  port_clocking_select_in,
  input  wire logic                        master_smbus_slow_strap_in,
  input  wire logic                        merge_pair_0_1_n_in,
  input  wire logic                        merge_pair_2_3_n_in,
  input  wire logic                        merge_pair_4_5_n_in,
  input  wire logic                        merge_pair_6_7_n_in,
  input  wire logic                        merge_pair_8_9_n_in,
  input  wire logic                        merge_pair_10_11_n_in,
  input  wire logic                        merge_pair_12_13_n_in,
  input  wire logic                        merge_pair_14_15_n_in,
  input  wire logic                        reset_hold_strap_in,
  input  wire logic [3:0]                  switch_mode_strap_in,
  // AXI4-Lite slave
  input  wire logic [ssd_pkg::ADDR_W-1:0]  s_axi_awaddr_in,
  input  wire logic                        s_axi_awvalid_in,
  output logic                             s_axi_awready_out,
  input  wire logic [ssd_pkg::DATA_W-1:0]  s_axi_wdata_in,
  input  wire logic [3:0]                  s_axi_wstrb_in,
  input  wire logic                        s_axi_wvalid_in,
  output logic                             s_axi_wready_out,
  output logic [1:0]                       s_axi_bresp_out,
  output logic                             s_axi_bvalid_out,
  input  wire logic                        s_axi_bready_in,
  input  wire logic [ssd_pkg::ADDR_W-1:0]  s_axi_araddr_in,
  input  wire logic                        s_axi_arvalid_in,
  output logic                             s_axi_arready_out,
  output logic [ssd_pkg::DATA_W-1:0]       s_axi_rdata_out,
  output logic [1:0]                       s_axi_rresp_out,
  output logic                             s_axi_rvalid_out,
  input  wire logic                        s_axi_rready_in,
  // Decoded configuration
  output logic [2:0]                       port_clocking_mode_out,
  output logic                             smbus_slow_out,
  output logic                             smbus_bit_tick_out,
  output logic                             smbus_enable_out,
  output logic [ssd_pkg::NUM_PORTS-1:0]    port_active_out,
  output logic [ssd_pkg::NUM_PORTS-1:0]    port_x8_out,
  output logic [3:0]                       upstream_port_out,
  output logic                             multi_partition_out,
  output logic                             eeprom_init_out,
  output logic                             mode_reserved_out,
  output logic                             core_reset_n_out
);

  localparam int unsigned AW = ssd_pkg::ADDR_W;
  localparam int unsigned DW = ssd_pkg::DATA_W;
  localparam int unsigned NP = ssd_pkg::NUM_PORTS;

  typedef struct packed {
    ssd_pkg::ssd_phase_t          phase;
    logic [ssd_pkg::DIV_W-1:0]    cnt;
    ssd_pkg::ssd_strap_t          straps;
    logic                         halt;
    logic                         core_rst_n;
    logic                         smbus_en;
    logic [NP-1:0]                port_active;
    logic [NP-1:0]                port_x8;
    logic [3:0]                   upstream;
    logic                         multi;
    logic                         eeprom;
    logic                         reserved;
    logic [ssd_pkg::DIV_W-1:0]    div;
    logic                         tick;
    logic                         aw_hold;
    logic [AW-1:0]                awaddr;
    logic                         w_hold;
    logic [DW-1:0]                wdata;
    logic [3:0]                   wstrb;
    logic                         awready;
    logic                         wready;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         arready;
    logic                         rvalid;
    logic [DW-1:0]                rdata;
    logic [1:0]                   rresp;
  } ssd_state_t;

  ssd_state_t s_q;
  ssd_state_t s_d;

  ssd_pkg::ssd_strap_t pin_straps;
  ssd_pkg::ssd_strap_t sync_straps;
  logic [NP-1:0]       present_w;
  logic [NP-1:0]       x8_w;
  logic [NP-1:0]       disable_w;
  logic [3:0]          up_w;
  logic                multi_w;
  logic                ee_w;
  logic                rsvd_w;
  logic [DW-1:0]       ctl_word;
  logic [DW-1:0]       stat_word;
  logic [DW-1:0]       port_word;
  logic [ssd_pkg::DIV_W-1:0] div_limit;

  // Bundle the pins; pair order follows the port numbering
  always_comb begin
    pin_straps.clk_mode   = port_clocking_select_in;
    pin_straps.smbus_slow = master_smbus_slow_strap_in;
    pin_straps.merge_n    = {merge_pair_14_15_n_in, merge_pair_12_13_n_in,
                             merge_pair_10_11_n_in, merge_pair_8_9_n_in,
                             merge_pair_6_7_n_in,   merge_pair_4_5_n_in,
                             merge_pair_2_3_n_in,   merge_pair_0_1_n_in};
    pin_straps.hold       = reset_hold_strap_in;
    pin_straps.sw_mode    = switch_mode_strap_in;
  end

  // Straps are board levels, so they cross into the core clock first
  ssd_sync #(
    .W (ssd_pkg::STRAP_W)
  ) u_strap_sync (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .d_in       (pin_straps),
    .q_out      (sync_straps)
  );

  // Per-pair port geometry: even port owns lanes 4..7 of the odd one when merged
  genvar gi;
  generate
    for (gi = 0; gi < ssd_pkg::NUM_PAIRS; gi++) begin : g_pair
      assign x8_w[2*gi]        = ~sync_straps.merge_n[gi];
      assign x8_w[2*gi+1]      = 1'b0;
      assign present_w[2*gi]   = 1'b1;
      assign present_w[2*gi+1] = sync_straps.merge_n[gi];
    end
  endgenerate

  // Switch mode decode; reserved codes fall back to the plain single partition
  always_comb begin
    up_w      = ssd_pkg::PORT_ZERO;
    multi_w   = 1'b0;
    ee_w      = 1'b0;
    rsvd_w    = 1'b0;
    disable_w = '0;
    case (sync_straps.sw_mode)
      ssd_pkg::MODE_SINGLE: begin
        up_w = ssd_pkg::PORT_ZERO;
      end
      ssd_pkg::MODE_SINGLE_EE: begin
        ee_w = 1'b1;
      end
      ssd_pkg::MODE_UP0_NO2, ssd_pkg::MODE_UP0_NO2_EE: begin
        disable_w[ssd_pkg::PORT_TWO] = 1'b1;
        ee_w = (sync_straps.sw_mode == ssd_pkg::MODE_UP0_NO2_EE);
      end
      ssd_pkg::MODE_UP2_NO0, ssd_pkg::MODE_UP2_NO0_EE: begin
        up_w = ssd_pkg::PORT_TWO;
        disable_w[ssd_pkg::PORT_ZERO] = 1'b1;
        ee_w = (sync_straps.sw_mode == ssd_pkg::MODE_UP2_NO0_EE);
      end
      ssd_pkg::MODE_MULTI, ssd_pkg::MODE_MULTI_EE: begin
        multi_w = 1'b1;
        ee_w    = (sync_straps.sw_mode == ssd_pkg::MODE_MULTI_EE);
      end
      default: begin
        rsvd_w = 1'b1;
      end
    endcase
  end

  // Read-back words built from latched state only
  always_comb begin
    ctl_word  = '0;
    stat_word = '0;
    port_word = '0;
    ctl_word[ssd_pkg::CTL_HALT_BIT]           = s_q.halt;
    stat_word[ssd_pkg::STAT_CLK_LSB +: 3]     = s_q.straps.clk_mode;
    stat_word[ssd_pkg::STAT_SLOW_BIT]         = s_q.straps.smbus_slow;
    stat_word[ssd_pkg::STAT_HOLD_BIT]         = s_q.straps.hold;
    stat_word[ssd_pkg::STAT_MODE_LSB +: 4]    = s_q.straps.sw_mode;
    stat_word[ssd_pkg::STAT_MULTI_BIT]        = s_q.multi;
    stat_word[ssd_pkg::STAT_EE_BIT]           = s_q.eeprom;
    stat_word[ssd_pkg::STAT_RSVD_BIT]         = s_q.reserved;
    stat_word[ssd_pkg::STAT_RUN_BIT]          = s_q.core_rst_n;
    stat_word[ssd_pkg::STAT_UP_LSB +: 4]      = s_q.upstream;
    stat_word[ssd_pkg::STAT_MERGE_LSB +: 8]   = s_q.straps.merge_n;
    port_word[ssd_pkg::PORT_ACT_LSB +: NP]    = s_q.port_active;
    port_word[ssd_pkg::PORT_X8_LSB +: NP]     = s_q.port_x8;
  end

  // The slow strap alone picks the rate; nothing in the map can change it
  assign div_limit = s_q.straps.smbus_slow ?
                     ssd_pkg::DIV_W'(ssd_pkg::SMBUS_SLOW_CYC - 1) :
                     ssd_pkg::DIV_W'(ssd_pkg::SMBUS_FAST_CYC - 1);

  // Next-state logic: bus slave first so a capture in the same cycle wins
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;

    // Write address and data are taken independently and held until paired
    if (s_axi_awvalid_in && s_q.awready) begin
      s_d.aw_hold = 1'b1;
      s_d.awaddr  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_q.wready) begin
      s_d.w_hold = 1'b1;
      s_d.wdata  = s_axi_wdata_in;
      s_d.wstrb  = s_axi_wstrb_in;
    end
    if (s_q.bvalid && s_axi_bready_in) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_hold && s_q.w_hold && !s_q.bvalid) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = ssd_pkg::RESP_OKAY;
      if ({s_q.awaddr[AW-1:2], 2'b00} == ssd_pkg::OFS_SWITCH_CTL) begin
        // Software may only clear the halt bit, never set it
        if (s_q.wstrb[0] && !s_q.wdata[ssd_pkg::CTL_HALT_BIT]) begin
          s_d.halt = 1'b0;
        end
      end else if ({s_q.awaddr[AW-1:2], 2'b00} == ssd_pkg::OFS_STRAP_STAT) begin
        s_d.bresp = ssd_pkg::RESP_OKAY;
      end else if ({s_q.awaddr[AW-1:2], 2'b00} == ssd_pkg::OFS_PORT_CFG) begin
        s_d.bresp = ssd_pkg::RESP_OKAY;
      end else begin
        s_d.bresp = ssd_pkg::RESP_DECERR;
      end
    end

    // Read channel: one outstanding read, answered the next cycle
    if (s_q.rvalid && s_axi_rready_in) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = ssd_pkg::RESP_OKAY;
      if ({s_axi_araddr_in[AW-1:2], 2'b00} == ssd_pkg::OFS_SWITCH_CTL) begin
        s_d.rdata = ctl_word;
      end else if ({s_axi_araddr_in[AW-1:2], 2'b00} == ssd_pkg::OFS_STRAP_STAT) begin
        s_d.rdata = stat_word;
      end else if ({s_axi_araddr_in[AW-1:2], 2'b00} == ssd_pkg::OFS_PORT_CFG) begin
        s_d.rdata = port_word;
      end else begin
        s_d.rdata = '0;
        s_d.rresp = ssd_pkg::RESP_DECERR;
      end
    end

    // Boot sequence
    case (s_q.phase)
      ssd_pkg::PH_SETTLE: begin
        // Wait out the synchroniser so stale reset values are not captured
        if (s_q.cnt == ssd_pkg::DIV_W'(ssd_pkg::SYNC_SETTLE_CYC - 1)) begin
          s_d.phase = ssd_pkg::PH_CAPTURE;
          s_d.cnt   = '0;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      ssd_pkg::PH_CAPTURE: begin
        // Single snapshot; later pin changes are ignored until next reset
        s_d.straps      = sync_straps;
        s_d.port_active = present_w & ~disable_w;
        s_d.port_x8     = x8_w;
        s_d.upstream    = up_w;
        s_d.multi       = multi_w;
        s_d.eeprom      = ee_w;
        s_d.reserved    = rsvd_w;
        s_d.halt        = sync_straps.hold;
        s_d.smbus_en    = 1'b1;
        s_d.phase       = ssd_pkg::PH_PROC;
        s_d.cnt         = '0;
      end
      ssd_pkg::PH_PROC: begin
        if (s_q.cnt == ssd_pkg::DIV_W'(ssd_pkg::RESET_PROC_CYC - 1)) begin
          s_d.cnt = '0;
          if (s_q.halt) begin
            s_d.phase = ssd_pkg::PH_HALT;
          end else begin
            s_d.phase      = ssd_pkg::PH_RUN;
            s_d.core_rst_n = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      ssd_pkg::PH_HALT: begin
        // Core stays in reset while SMBus traffic goes on
        if (!s_q.halt) begin
          s_d.phase      = ssd_pkg::PH_RUN;
          s_d.core_rst_n = 1'b1;
        end
      end
      default: begin
        s_d.phase = ssd_pkg::PH_RUN;
      end
    endcase

    // Master SMBus bit-rate enable, running from capture onward
    if (s_q.smbus_en) begin
      if (s_q.div >= div_limit) begin
        s_d.div  = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.div = s_q.div + 1'b1;
      end
    end

    // Ready flags follow what is held so every bus output is a flop
    s_d.awready = !s_d.aw_hold && !s_d.bvalid;
    s_d.wready  = !s_d.w_hold && !s_d.bvalid;
    s_d.arready = !s_d.rvalid;
  end

  // Global reset clears everything; merge defaults read as merged
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q         <= '0;
      s_q.phase   <= ssd_pkg::PH_SETTLE;
      s_q.straps  <= ssd_pkg::STRAP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready_out      = s_q.awready;
  assign s_axi_wready_out       = s_q.wready;
  assign s_axi_bvalid_out       = s_q.bvalid;
  assign s_axi_bresp_out        = s_q.bresp;
  assign s_axi_arready_out      = s_q.arready;
  assign s_axi_rvalid_out       = s_q.rvalid;
  assign s_axi_rdata_out        = s_q.rdata;
  assign s_axi_rresp_out        = s_q.rresp;
  assign port_clocking_mode_out = s_q.straps.clk_mode;
  assign smbus_slow_out         = s_q.straps.smbus_slow;
  assign smbus_bit_tick_out     = s_q.tick;
  assign smbus_enable_out       = s_q.smbus_en;
  assign port_active_out        = s_q.port_active;
  assign port_x8_out            = s_q.port_x8;
  assign upstream_port_out      = s_q.upstream;
  assign multi_partition_out    = s_q.multi;
  assign eeprom_init_out        = s_q.eeprom;
  assign mode_reserved_out      = s_q.reserved;
  assign core_reset_n_out       = s_q.core_rst_n;

endmodule : ssd_strap_decoder

// File: verification/ssd_strap_decoder_props.sv
// Checker for strap capture, mode decode and reset halt timing
`timescale 1ns/1ps
module ssd_strap_decoder_props (
  input wire logic        mclk_in,
  input wire logic        reset_n_in,
  input wire logic [2:0]  port_clocking_select_in,
  input wire logic        master_smbus_slow_strap_in,
  input wire logic        merge_pair_0_1_n_in,
  input wire logic        reset_hold_strap_in,
  input wire logic [3:0]  switch_mode_strap_in,
  input wire logic [2:0]  port_clocking_mode_out,
  input wire logic        smbus_slow_out,
  input wire logic        smbus_enable_out,
  input wire logic [15:0] port_active_out,
  input wire logic [15:0] port_x8_out,
  input wire logic [3:0]  upstream_port_out,
  input wire logic        multi_partition_out,
  input wire logic        eeprom_init_out,
  input wire logic        core_reset_n_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // Straps are held by the bench across capture, so outputs must mirror them
  a_clk_capture: assert property ($rose(smbus_enable_out) |->
    port_clocking_mode_out == port_clocking_select_in) else $error("clock mode not captured");
  a_slow_capture: assert property ($rose(smbus_enable_out) |->
    smbus_slow_out == master_smbus_slow_strap_in) else $error("slow strap not captured");
  a_pair_merge: assert property ($rose(smbus_enable_out) |->
    port_x8_out[0] == !merge_pair_0_1_n_in && port_active_out[1] == merge_pair_0_1_n_in)
    else $error("pair 0/1 merge wrong");
  a_mode_decode: assert property ($rose(smbus_enable_out) |->
    multi_partition_out == (switch_mode_strap_in[3:1] == 3'b110) &&
    upstream_port_out == (switch_mode_strap_in inside {4'h9, 4'hB} ? 4'h2 : 4'h0) &&
    eeprom_init_out == (switch_mode_strap_in inside {4'h1, 4'hA, 4'hB, 4'hD}))
    else $error("switch mode decode wrong");
  // Once captured nothing may follow the pins until the next reset
  a_straps_frozen: assert property ($past(smbus_enable_out) && smbus_enable_out |->
    $stable(port_clocking_mode_out) && $stable(port_x8_out) && $stable(upstream_port_out))
    else $error("config moved after capture");
  a_reset_clear: assert property ($rose(reset_n_in) |-> !smbus_enable_out &&
    !core_reset_n_out && port_x8_out == 16'h0000) else $error("outputs not cleared by reset");
  a_halt_hold: assert property ($rose(smbus_enable_out) && reset_hold_strap_in |->
    !core_reset_n_out [*8]) else $error("core left reset while halted");
  a_proc_time: assert property ($rose(smbus_enable_out) && !reset_hold_strap_in |->
    ##99 !core_reset_n_out ##1 core_reset_n_out) else $error("reset procedure length wrong");
  a_proc_min: assert property ($rose(core_reset_n_out) |->
    $past(smbus_enable_out, 100)) else $error("core released too early");
  c_halted: cover property ($rose(smbus_enable_out) && reset_hold_strap_in);
  c_running: cover property ($rose(core_reset_n_out));
  c_multi: cover property ($rose(multi_partition_out));
endmodule : ssd_strap_decoder_props

bind ssd_strap_decoder ssd_strap_decoder_props u_props (.*);

// File: verification/ssd_board_model.sv
// Board strap model driving the strap pins, merge straps able to float
`timescale 1ns/1ps
module ssd_board_model (
  input  wire logic                float_in,
  input  wire ssd_pkg::ssd_strap_t cfg_in,
  output ssd_pkg::ssd_strap_t      pins_out
);
  // A floating merge strap falls to its pull-down, so it reads as merged
  always_comb begin
    pins_out = cfg_in;
    if (float_in) begin
      pins_out.merge_n = 8'h00;
    end
  end
endmodule : ssd_board_model

// File: verification/tb_top.sv
// Testbench: boots with varied straps, decode, halt release and register checks
`timescale 1ns/1ps
module tb_top;
  logic mclk_in, reset_n_in, float_q, master_smbus_slow_strap_in, reset_hold_strap_in;
  logic merge_pair_0_1_n_in, merge_pair_2_3_n_in, merge_pair_4_5_n_in, merge_pair_6_7_n_in;
  logic merge_pair_8_9_n_in, merge_pair_10_11_n_in, merge_pair_12_13_n_in;
  logic merge_pair_14_15_n_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
  logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in;
  logic s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, smbus_slow_out;
  logic smbus_bit_tick_out, smbus_enable_out, multi_partition_out, eeprom_init_out;
  logic mode_reserved_out, core_reset_n_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rd_r;
  logic [2:0]  port_clocking_select_in, port_clocking_mode_out;
  logic [3:0]  switch_mode_strap_in, s_axi_wstrb_in, upstream_port_out;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
  logic [15:0] port_active_out, port_x8_out;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd_d;
  ssd_pkg::ssd_strap_t cfg_q, pins;
  int failures = 0, cmp_count = 0, cyc = 0, seed = 32'hffb3256f;
  // Board applies only defined mode codes
  logic [3:0] modes [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};

  ssd_board_model u_board (.float_in(float_q), .cfg_in(cfg_q), .pins_out(pins));
  assign {port_clocking_select_in, master_smbus_slow_strap_in, merge_pair_14_15_n_in,
          merge_pair_12_13_n_in, merge_pair_10_11_n_in, merge_pair_8_9_n_in,
          merge_pair_6_7_n_in, merge_pair_4_5_n_in, merge_pair_2_3_n_in,
          merge_pair_0_1_n_in, reset_hold_strap_in, switch_mode_strap_in} = pins;
  ssd_strap_decoder dut (.*);

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // Expected port config word: x8 flags high half, active flags low half
  function automatic logic [31:0] exp_ports(ssd_pkg::ssd_strap_t s);
    logic [15:0] act, x8;
    act = 16'hFFFF;
    x8 = 16'h0000;
    for (int p = 0; p < 8; p++) begin
      x8[2*p] = !s.merge_n[p];
      act[2*p+1] = s.merge_n[p];
    end
    if (s.sw_mode inside {4'h8, 4'hA}) act[2] = 1'b0;
    if (s.sw_mode inside {4'h9, 4'hB}) act[0] = 1'b0;
    return {x8, act};
  endfunction : exp_ports

  // Expected strap status word with the core running
  function automatic logic [31:0] exp_stat(ssd_pkg::ssd_strap_t s);
    logic [3:0] m;
    m = s.sw_mode;
    return {s.merge_n, 4'h0, (m inside {4'h9, 4'hB}) ? 4'h2 : 4'h0, 2'b10,
            m inside {4'h1, 4'hA, 4'hB, 4'hD}, m[3:1] == 3'b110, m, 3'h0,
            s.hold, s.smbus_slow, s.clk_mode};
  endfunction : exp_stat

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
    do begin
      @(posedge mclk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    r = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_in);
    s_axi_araddr_in <= a;
    {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
    do begin
      @(posedge mclk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask : axi_rd

  // One boot: reset, capture, optional halt release, then readback
  task automatic boot(input logic fl, input logic hd, input logic [3:0] md);
    ssd_pkg::ssd_strap_t e;
    int n;
    reset_n_in <= 1'b0;
    float_q <= fl;
    e = {3'($random(seed)), 1'($random(seed)), 8'($random(seed)), hd, md};
    cfg_q <= e;
    if (fl) e.merge_n = 8'h00;
    repeat (10) @(posedge mclk_in);
    chk("reset outputs", {core_reset_n_out, smbus_enable_out, port_active_out}, 0);
    reset_n_in <= 1'b1;
    do @(posedge mclk_in); while (smbus_enable_out !== 1'b1);
    if (hd) begin
      repeat (120) @(posedge mclk_in);
      chk("halted core", core_reset_n_out, 0);
      axi_rd(8'h00, rd_d, rd_r);
      chk("halt bit", rd_d, 1);
      axi_wr(8'h00, 0, rd_r);
      chk("halt write resp", rd_r, 0);
    end
    do @(posedge mclk_in); while (core_reset_n_out !== 1'b1);
    axi_rd(8'h04, rd_d, rd_r);
    chk("strap status", rd_d, exp_stat(e));
    axi_rd(8'h08, rd_d, rd_r);
    chk("port config", rd_d, exp_ports(e));
    chk("port outputs", {port_x8_out, port_active_out}, exp_ports(e));
    chk("reserved flag", mode_reserved_out, 0);
    axi_rd(8'h00, rd_d, rd_r);
    chk("halt clear", rd_d, 0);
    // Clock, slow and merge pins move after release; mode and hold straps stay put as the board keeps them
    cfg_q.clk_mode <= ~cfg_q.clk_mode;
    cfg_q.smbus_slow <= ~cfg_q.smbus_slow;
    cfg_q.merge_n <= ~cfg_q.merge_n;
    do @(posedge mclk_in); while (smbus_bit_tick_out !== 1'b1);
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (smbus_bit_tick_out !== 1'b1);
    chk("tick spacing", n, ssd_pkg::CLK_FREQ_MHZ * 1000 / (e.smbus_slow ? 100 : 400));
    axi_rd(8'h04, rd_d, rd_r);
    chk("status after pin change", rd_d, exp_stat(e));
  endtask : boot

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // Hang guard well above twelve boots with slow ticks
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    {reset_n_in, float_q, cfg_q, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h0;
    s_axi_rready_in = 1'b0;
    s_axi_wstrb_in = 4'hF;
    for (int i = 0; i < 12; i++) begin
      boot(i == 0, i[0], modes[i%8]);
      $display("boot %0d done", i);
    end
    axi_rd(8'h0C, rd_d, rd_r);
    chk("unmapped resp", rd_r, 3);
    chk("unmapped data", rd_d, 0);
    $display("unmapped read done");
    end_of_test();
  end
endmodule : tb_top
